/* File: logic/cpt_timer.v */
// How it works
// [R1] mode 00 compare, 10 pwm, 11 timer
// [R2] software stops timer before changing mode
// [R3] compare match: none, low, high, toggle
// [R4] pwm: force inactive, force active, wave
// [R5] action equal to initial level shows nothing
// [R6] counter on rising restores initial pin level
// [R7] software changes pwm action only when stopped
// [R8] initial level or pwm active level bit
// [R9] invert bit inverts pins except timer mode
// [R10] swap bit exchanges period and duty sources
// [R11] clear source: A match, else P/overflow
// [R12] overflow clear only when P bits zero
// [R13] clear source ignored in pwm mode
// [R14] counter readable as low/high byte pair
// [R15] compare A held in low/high byte pair
// [R16] clear source 0 raises both flags
// [R17] clear source 1 raises only A flag
// [R18] compare A zero: overflow, no A flag
// [R19] only A match changes the pin
// [R20] timer mode leaves pin unused
// [R21] on rising zeroes counter, falling holds it
// [R22] P compares counter bits 9 to 7
// [R23] low bytes pass through shared buffer
// [R24] flags sticky, set in the match cycle
`timescale 1ns/100ps
`default_nettype none
`include "cpt_defs.vh"

module cpt_timer #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // pins
  output reg timer_output_pin,
  output reg timer_output_pin_inverted,
  // flags
  output reg match_a_flag,
  output reg match_p_flag
);

  // ==========================================================
  // bus state
  reg rd_pend_q;
  reg wr_pend_q;
  reg [7:0] addr_q;
  reg [7:0] buf_q;

  // ==========================================================
  // registers
  reg [7:0] ctl0_q;
  reg [7:0] ctl1_q;
  reg [9:0] cmpa_q;
  reg [9:0] cnt_q;
  reg on_prev_q;
  reg pin_q;

  wire take;
  wire [7:0] a_lo;
  wire wr_go;
  wire rd_go;

  assign take = hsel & htrans[1] & hready;
  assign a_lo = haddr[7:0];
  assign wr_go = wr_pend_q;
  assign rd_go = rd_pend_q;

  // ==========================================================
  // field views
  wire pause = ctl0_q[`CPT_C0_PAUSE];
  wire counter_on = ctl0_q[`CPT_C0_ON];
  wire [2:0] compare_p_value = ctl0_q[`CPT_C0_CMPP_HI:`CPT_C0_CMPP_LO];
  wire [1:0] mode = ctl1_q[`CPT_C1_MODE_HI:`CPT_C1_MODE_LO];
  wire [1:0] pin_action = ctl1_q[`CPT_C1_IO_HI:`CPT_C1_IO_LO];
  wire output_initial_level = ctl1_q[`CPT_C1_INIT];
  wire output_invert = ctl1_q[`CPT_C1_INV];
  wire period_duty_swap = ctl1_q[`CPT_C1_SWAP];
  wire clear_source_select = ctl1_q[`CPT_C1_CLRSRC];

  wire is_cmp = (mode == `CPT_MODE_CMP); // see [R1]
  wire is_pwm = (mode == `CPT_MODE_PWM); // see [R1]
  wire is_tmr = (mode == `CPT_MODE_TMR); // see [R1]

  // ==========================================================
  // counter and comparators
  wire on_rise = counter_on & ~on_prev_q;
  wire run = counter_on & ~pause & ~on_rise;
  wire [9:0] cnt_inc = cnt_q + 10'h001;
  wire ovf = run & (cnt_q == `CPT_CNT_MAX);
  wire p_zero = (compare_p_value == 3'h0);
  // match is taken when the next count would reach the target,
  // so a target of n gives a period of exactly n ticks
  wire m_a = run & (cmpa_q != 10'h000) & (cnt_inc == cmpa_q); // see [R18]
  wire m_p = run & ~p_zero & (cnt_inc == {compare_p_value, 7'h00}); // see [R22]
  wire p_wrap = p_zero & ovf; // see [R12]

  reg clr;
  reg set_a;
  reg set_p;

  always @* begin
    clr = 1'b0;
    set_a = m_a;
    set_p = m_p;
    if (is_pwm) begin
      // clear source select plays no part here
      if (period_duty_swap) begin
        clr = m_a; // see [R10] [R13]
      end else begin
        clr = m_p | p_wrap; // see [R10] [R13]
      end
    end else if (clear_source_select) begin
      clr = m_a; // see [R11]
      set_p = 1'b0; // see [R17]
    end else begin
      clr = m_p | p_wrap; // see [R11] [R12] [R16]
    end
  end

  // ==========================================================
  // pwm waveform
  reg [10:0] duty;

  always @* begin
    if (period_duty_swap) begin
      duty = p_zero ? `CPT_P_FULL : {1'b0, compare_p_value, 7'h00}; // see [R10]
    end else begin
      duty = {1'b0, cmpa_q}; // see [R10]
    end
  end

  // a duty at or past the period simply keeps the wave active
  wire pwm_act = ({1'b0, cnt_q} < duty);

  reg pwm_lvl;

  always @* begin
    case (pin_action)
      `CPT_IO_PWM_ON: pwm_lvl = output_initial_level; // see [R4] [R8]
      `CPT_IO_PWM_WAVE: pwm_lvl = pwm_act ? output_initial_level
                                          : ~output_initial_level; // see [R4] [R8]
      default: pwm_lvl = ~output_initial_level; // see [R4]
    endcase
  end

  // ==========================================================
  // compare match pin action
  reg cmp_lvl;

  always @* begin
    cmp_lvl = pin_q;
    if (m_a) begin
      case (pin_action)
        `CPT_IO_LOW: cmp_lvl = 1'b0; // see [R3] [R5]
        `CPT_IO_HIGH: cmp_lvl = 1'b1; // see [R3] [R5]
        `CPT_IO_TOGGLE: cmp_lvl = ~pin_q; // see [R3]
        default: cmp_lvl = pin_q; // see [R3]
      endcase
    end
  end

  // ==========================================================
  // timer core
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= `CPT_RST_CNT;
      on_prev_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      on_prev_q <= counter_on;
      if (on_rise) begin
        cnt_q <= `CPT_RST_CNT; // see [R21]
      end else if (run) begin
        cnt_q <= clr ? `CPT_RST_CNT : cnt_inc; // see [R11]
      end
      if (on_rise) begin
        pin_q <= output_initial_level; // see [R6] [R8]
      end else if (is_pwm) begin
        pin_q <= pwm_lvl;
      end else if (is_cmp) begin
        pin_q <= cmp_lvl; // see [R19]
      end
    end
  end

  // ==========================================================
  // pin drivers
  reg pin_out;

  always @* begin
    if (is_tmr) begin
      pin_out = 1'b0; // see [R20]
    end else begin
      pin_out = pin_q ^ output_invert; // see [R9]
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_output_pin <= 1'b0;
      timer_output_pin_inverted <= 1'b1;
    end else begin
      timer_output_pin <= pin_out;
      timer_output_pin_inverted <= ~pin_out;
    end
  end

  // ==========================================================
  // flags: a set in the clearing cycle wins
  wire wr_flags = wr_go & (addr_q == `CPT_OFS_FLAGS);
  wire clr_a = wr_flags & hwdata[`CPT_FL_A];
  wire clr_p = wr_flags & hwdata[`CPT_FL_P];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= (match_a_flag & ~clr_a) | set_a; // see [R24] [R16]
      match_p_flag <= (match_p_flag & ~clr_p) | set_p; // see [R24] [R17]
    end
  end

  // ==========================================================
  // bus slave
  // reads take one wait state so a write just ahead is seen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (rd_go) begin
        rd_pend_q <= 1'b0;
        hreadyout <= 1'b1;
      end else if (take) begin
        addr_q <= {a_lo[7:2], 2'h0};
        rd_pend_q <= ~hwrite;
        hreadyout <= hwrite;
      end
      wr_pend_q <= take & hwrite & ~rd_go;
    end
  end

  // ==========================================================
  // register file
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl0_q <= `CPT_RST_CTRL;
      ctl1_q <= `CPT_RST_CTRL;
      cmpa_q <= `CPT_RST_CNT;
      buf_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        case (addr_q)
          `CPT_OFS_CTRL_ZERO: ctl0_q <= hwdata[7:0] & 8'h8f;
          `CPT_OFS_CTRL_ONE: ctl1_q <= hwdata[7:0];
          `CPT_OFS_CMPA_LOW: buf_q <= hwdata[7:0]; // see [R23]
          `CPT_OFS_CMPA_HIGH: cmpa_q <= {hwdata[1:0], buf_q}; // see [R15] [R23]
          default: ;
        endcase
      end
      if (rd_go) begin
        case (addr_q)
          `CPT_OFS_CTRL_ZERO: hrdata <= {24'h000000, ctl0_q};
          `CPT_OFS_CTRL_ONE: hrdata <= {24'h000000, ctl1_q};
          `CPT_OFS_CNT_LOW: hrdata <= {24'h000000, buf_q}; // see [R23]
          `CPT_OFS_CNT_HIGH: begin
            hrdata <= {30'h00000000, cnt_q[9:8]}; // see [R14]
            buf_q <= cnt_q[7:0]; // see [R23]
          end
          `CPT_OFS_CMPA_LOW: hrdata <= {24'h000000, buf_q}; // see [R23]
          `CPT_OFS_CMPA_HIGH: begin
            hrdata <= {30'h00000000, cmpa_q[9:8]}; // see [R15]
            buf_q <= cmpa_q[7:0]; // see [R23]
          end
          `CPT_OFS_FLAGS: hrdata <= {30'h00000000, match_p_flag, match_a_flag};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* File: shared/cpt_defs.vh */
`ifndef CPT_DEFS_VH
`define CPT_DEFS_VH

// ==========================================================
// register byte offsets
`define CPT_OFS_CTRL_ZERO 8'h00
`define CPT_OFS_CTRL_ONE 8'h04
`define CPT_OFS_CNT_LOW 8'h08
`define CPT_OFS_CNT_HIGH 8'h0c
`define CPT_OFS_CMPA_LOW 8'h10
`define CPT_OFS_CMPA_HIGH 8'h14
`define CPT_OFS_FLAGS 8'h18

// ==========================================================
// control zero fields
`define CPT_C0_PAUSE 7
`define CPT_C0_ON 3
`define CPT_C0_CMPP_HI 2
`define CPT_C0_CMPP_LO 0

// ==========================================================
// control one fields
`define CPT_C1_MODE_HI 7
`define CPT_C1_MODE_LO 6
`define CPT_C1_IO_HI 5
`define CPT_C1_IO_LO 4
`define CPT_C1_INIT 3
`define CPT_C1_INV 2
`define CPT_C1_SWAP 1
`define CPT_C1_CLRSRC 0

// ==========================================================
// flags fields
`define CPT_FL_A 0
`define CPT_FL_P 1

// ==========================================================
// mode and pin action codes
`define CPT_MODE_CMP 2'h0
`define CPT_MODE_PWM 2'h2
`define CPT_MODE_TMR 2'h3
`define CPT_IO_NONE 2'h0
`define CPT_IO_LOW 2'h1
`define CPT_IO_HIGH 2'h2
`define CPT_IO_TOGGLE 2'h3
`define CPT_IO_PWM_OFF 2'h0
`define CPT_IO_PWM_ON 2'h1
`define CPT_IO_PWM_WAVE 2'h2

// ==========================================================
// reset values and widths
`define CPT_RST_CTRL 8'h00
`define CPT_RST_CNT 10'h000
`define CPT_CNT_MAX 10'h3ff
`define CPT_P_FULL 11'h400

`endif

/* File: test/cpt_pin_load.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// pin load: counts level changes on the timer pin
module cpt_pin_load (
  // pins
  input wire logic hclk,
  input wire logic pin,
  // observed
  output int moves
);
  logic last_q;
  initial moves = 0;
  always @(posedge hclk) begin
    if (pin !== last_q) moves <= moves + 1;
    last_q <= pin;
  end
endmodule
`default_nettype wire

/* File: test/cpt_timer_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// bus and flag checks
module cpt_timer_chk #(
  parameter ADDR_W = 8
) (
  // bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  // pins and flags
  input wire timer_output_pin,
  input wire timer_output_pin_inverted,
  input wire match_a_flag,
  input wire match_p_flag
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd, wr, wfl_q;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  assign wr = hsel && htrans[1] && hready && hwrite;
  // a flag may only drop in the data phase of a flags write
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wfl_q <= 1'b0;
    else wfl_q <= wr && haddr[7:2] == 6'h06;
  a_twin_pins: assert property (
    timer_output_pin_inverted == !timer_output_pin) else $error("twin pin not inverse");
  a_read_wait: assert property (
    rd |=> !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
  a_write_nowait: assert property (
    wr |=> hreadyout) else $error("write stalled");
  a_rdata_held: assert property (
    hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("read data moved");
  a_unmapped_zero: assert property (
    rd && haddr[7:2] > 6'h06 |=> ##1 hrdata == 32'h0) else $error("unmapped read not 0");
  a_cnt_high_bits: assert property (
    rd && haddr[7:2] == 6'h03 |=> ##1 hrdata[31:2] == 30'h0) else $error("count high bits");
  a_cmpa_high_bits: assert property (
    rd && haddr[7:2] == 6'h05 |=> ##1 hrdata[31:2] == 30'h0) else $error("cmp a high bits");
  a_flag_a_sticky: assert property (
    match_a_flag && !wfl_q |=> match_a_flag) else $error("flag a dropped");
  a_flag_p_sticky: assert property (
    match_p_flag && !wfl_q |=> match_p_flag) else $error("flag p dropped");
  c_flag_a: cover property ($rose(match_a_flag));
  c_flag_p: cover property ($rose(match_p_flag));
  c_pin_move: cover property ($changed(timer_output_pin));
endmodule
bind cpt_timer cpt_timer_chk #(.ADDR_W(ADDR_W)) u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .timer_output_pin,
  .timer_output_pin_inverted, .match_a_flag, .match_p_flag);
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pin, pin_n, fa, fp;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int moves;
  always #5 hclk = ~hclk;
  cpt_timer dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .timer_output_pin(pin),
    .timer_output_pin_inverted(pin_n), .match_a_flag(fa), .match_p_flag(fp));
  cpt_pin_load load (.hclk, .pin, .moves);
  // ==========
  // bus access
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    cmp(q, exp);
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    rd(8'h04, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h1c, 32'h0);
    cmp(32'({fa, fp}), 32'h0);
    cmp(32'(hresp), 32'h0);
  endtask
  task automatic t_buffer();
    wr(8'h10, 8'ha5);
    rd(8'h14, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h10, 8'ha5);
    wr(8'h14, 8'hff);
    rd(8'h14, 32'h3);
    rd(8'h10, 32'ha5);
  endtask
  // compare mode, clear on A: one match in the window, P below A stays silent
  task automatic t_actions();
    int m;
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, 8'h00);
      wr(8'h04, {2'b00, 2'(k), 4'h1});
      wr(8'h18, 8'h03);
      wr(8'h10, 8'hc8);
      wr(8'h14, 8'h00);
      wr(8'h00, 8'h09);
      // the pin load counts the restore move one edge late
      repeat (4) @(posedge hclk);
      m = moves;
      repeat (212) @(posedge hclk);
      cmp(32'(moves - m), 32'(k / 2));
      cmp(32'(pin), 32'(k / 2));
      cmp(32'({fa, fp}), 32'h2);
    end
  endtask
  task automatic t_clr_p();
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h30);
    wr(8'h18, 8'h03);
    wr(8'h10, 8'h32);
    wr(8'h14, 8'h00);
    wr(8'h00, 8'h09);
    repeat (300) @(posedge hclk);
    cmp(32'({fa, fp}), 32'h3);
    rd(8'h0c, 32'h0);
  endtask
  task automatic t_overflow();
    wr(8'h00, 8'h00);
    wr(8'h18, 8'h03);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h00, 8'h08);
    repeat (1100) @(posedge hclk);
    cmp(32'(fa), 32'h0);
    rd(8'h0c, 32'h0);
  endtask
  task automatic t_onoff();
    logic [31:0] h, l;
    wr(8'h00, 8'h00);
    xfer(1'b0, 8'h0c, 8'h00, h);
    xfer(1'b0, 8'h08, 8'h00, l);
    repeat (20) @(posedge hclk);
    rd(8'h0c, h);
    rd(8'h08, l);
    wr(8'h04, 8'h08);
    wr(8'h00, 8'h08);
    repeat (3) @(posedge hclk);
    cmp(32'(pin), 32'h1);
  endtask
  task automatic t_pwm();
    logic e;
    int hi;
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, 8'h00);
      wr(8'h04, {3'b100, 3'(k), 2'b00});
      wr(8'h00, 8'h08);
      repeat (4) @(posedge hclk);
      e = k[2] ^ !k[1] ^ k[0];
      cmp(32'(pin), 32'(e));
      cmp(32'(pin_n), 32'(!e));
    end
    // waveform: period 128 from P, duty 64 from A, active high
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h40);
    wr(8'h14, 8'h00);
    wr(8'h04, 8'ha8);
    wr(8'h00, 8'h09);
    repeat (8) @(posedge hclk);
    hi = 0;
    repeat (256) begin
      @(posedge hclk);
      if (pin === 1'b1) hi++;
    end
    cmp(32'(hi), 32'd128);
  endtask
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_buffer();
    t_actions();
    t_clr_p();
    t_overflow();
    t_onoff();
    t_pwm();
    give_verdict();
  end
  // the whole run needs about 3000 cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      give_verdict();
    end
  end
endmodule
`default_nettype wire
